/* File: design/tcr_pkg.sv */
package tcr_pkg;

   // Register index (printed offsets are not multiples of four)
   localparam logic [7:0] IDX_CONTROL    = 8'hC8;
   localparam logic [7:0] IDX_MODE       = 8'hC9;
   localparam logic [7:0] IDX_CAPLOW     = 8'hCA;
   localparam logic [7:0] IDX_CAPHIGH    = 8'hCB;
   localparam logic [7:0] IDX_COUNTLOW   = 8'hCC;
   localparam logic [7:0] IDX_COUNTHIGH  = 8'hCD;
   localparam logic [7:0] IDX_IRQSTATUS  = 8'hCE;
   localparam logic [7:0] IDX_IRQMASK    = 8'hCF;
   localparam logic [7:0] IDX_AUX        = 8'hD0;

   // Control register fields
   localparam int CTL_OVF   = 7;
   localparam int CTL_EXF   = 6;
   localparam int CTL_RXB   = 5;
   localparam int CTL_TXB   = 4;
   localparam int CTL_EXEN  = 3;
   localparam int CTL_RUN   = 2;
   localparam int CTL_CNT   = 1;
   localparam int CTL_CAP   = 0;

   // Mode register fields
   localparam int MOD_ACLR  = 3;
   localparam int MOD_COE   = 1;
   localparam int MOD_DOWN_COUNT_ENABLE  = 0;

   // Aux register fields
   localparam int AUX_FAST  = 0;

   // Interrupt status bits
   localparam int IRQ_OVF   = 0;
   localparam int IRQ_EXF   = 1;
   localparam int IRQ_CAPT  = 2;

   // Values after reset, and the all-ones count limit
   localparam logic [7:0]  RST_BYTE   = 8'h00;
   localparam logic [15:0] RST_COUNT  = 16'h0000;
   localparam logic [15:0] ALL_ONES   = 16'hFFFF;

   // Prescale: slow timer ticks every 12 clocks, fast every 4
   localparam logic [3:0]  DIV_SLOW   = 4'hC;
   localparam logic [3:0]  DIV_FAST   = 4'h4;
   localparam logic [3:0]  DIV_BAUD   = 4'h2;

   // AXI responses
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage

/* File: design/tcr_timer.sv */
// Behaviour
// - overflow flag set on wrap or down-count match, outside baud mode
// - overflow flag cleared only by software write
// - event flag set by trigger edge, or by overflow when down count enabled, outside baud mode
// - event flag raises interrupt when enabled
// - receive baud from timer2 when rx select
// - transmit baud from timer2 when tx select
// - either baud select forces baud generator
// - trigger edge ignored unless trigger enabled
// - count only while run bit set
// - timer or pin falling edge counting
// - baud mode advances every two clocks
// - baud mode always reloads on overflow
// - reload mode reloads on overflow, trigger edge
// - capture mode copies count on trigger edge
// - auto-clear count after capture when enabled
// - clock output only while output enabled
// - trigger level sets direction when down count, in plain auto-reload only
// - capture registers hold capture or reload
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module tcr_timer #(
   parameter int ADDR_W = 12
) (
   // Clock, reset, enable
   input  wire logic              CLK_SYS_I,
   input  wire logic              SYS_RST_I,
   input  wire logic              CLK_EN_I,
   // AXI4-Lite write
   input  wire logic [ADDR_W-1:0] S_AWADDR_I,
   input  wire logic              S_AWVALID_I,
   output      logic              S_AWREADY_O,
   input  wire logic [31:0]       S_WDATA_I,
   input  wire logic [3:0]        S_WSTRB_I,
   input  wire logic              S_WVALID_I,
   output      logic              S_WREADY_O,
   output      logic [1:0]        S_BRESP_O,
   output      logic              S_BVALID_O,
   input  wire logic              S_BREADY_I,
   // AXI4-Lite read
   input  wire logic [ADDR_W-1:0] S_ARADDR_I,
   input  wire logic              S_ARVALID_I,
   output      logic              S_ARREADY_O,
   output      logic [31:0]       S_RDATA_O,
   output      logic [1:0]        S_RRESP_O,
   output      logic              S_RVALID_O,
   input  wire logic              S_RREADY_I,
   // Pins and serial port links
   input  wire logic              EXT_TRIGGER_PIN_I,
   input  wire logic              COUNT_INPUT_PIN_I,
   input  wire logic              TIMER1_OVF_I,
   output      logic              CLOCK_OUT_O,
   output      logic              RX_BAUD_TICK_O,
   output      logic              TX_BAUD_TICK_O,
   output      logic              IRQ_O
);

   logic [7:0]  ctl;
   logic [7:0]  mode;
   logic [7:0]  aux;
   logic [15:0] cap;
   logic [15:0] cnt;
   logic [2:0]  irq_stat;
   logic [2:0]  irq_mask;
   logic        trig_q;
   logic        pin_q;
   logic [3:0]  pre;

   ////////////////////////////////////////////////////////////////////
   // AXI slave: address and data taken in either order
   logic              aw_held;
   logic              w_held;
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0]       w_data;
   logic [3:0]        w_strb;
   logic              wr_go;
   logic [7:0]        wr_idx;
   logic              wr_hit;

   function automatic logic [7:0] addr_idx(input logic [ADDR_W-1:0] a);
      return a[9:2];
   endfunction

   function automatic logic idx_ok(input logic [7:0] i,
                                   input logic [ADDR_W-1:0] a);
      return (i >= tcr_pkg::IDX_CONTROL) && (i <= tcr_pkg::IDX_AUX)
             && (a[ADDR_W-1:10] == '0);
   endfunction

   assign wr_go  = aw_held && w_held && !S_BVALID_O;
   assign wr_idx = addr_idx(aw_addr);
   assign wr_hit = wr_go && idx_ok(wr_idx, aw_addr) && w_strb[0];

   // Write strobe for one register; operands passed so that they are seen
   function automatic logic wr_to(input logic hit, input logic [7:0] idx,
                                  input logic [7:0] i);
      return hit && (idx == i);
   endfunction

   // Write strobes, one per register, decoded once
   logic wr_ctl;
   logic wr_mode;
   logic wr_aux;
   logic wr_capl;
   logic wr_caph;
   logic wr_cntl;
   logic wr_cnth;
   logic wr_irqs;
   logic wr_irqm;
   assign wr_ctl  = wr_to(wr_hit, wr_idx, tcr_pkg::IDX_CONTROL);
   assign wr_mode = wr_to(wr_hit, wr_idx, tcr_pkg::IDX_MODE);
   assign wr_aux  = wr_to(wr_hit, wr_idx, tcr_pkg::IDX_AUX);
   assign wr_capl = wr_to(wr_hit, wr_idx, tcr_pkg::IDX_CAPLOW);
   assign wr_caph = wr_to(wr_hit, wr_idx, tcr_pkg::IDX_CAPHIGH);
   assign wr_cntl = wr_to(wr_hit, wr_idx, tcr_pkg::IDX_COUNTLOW);
   assign wr_cnth = wr_to(wr_hit, wr_idx, tcr_pkg::IDX_COUNTHIGH);
   assign wr_irqs = wr_to(wr_hit, wr_idx, tcr_pkg::IDX_IRQSTATUS);
   assign wr_irqm = wr_to(wr_hit, wr_idx, tcr_pkg::IDX_IRQMASK);

   always_ff @(posedge CLK_SYS_I) begin
      if (SYS_RST_I) begin
         aw_held     <= 1'b0;
         w_held      <= 1'b0;
         aw_addr     <= '0;
         w_data      <= 32'h0000_0000;
         w_strb      <= 4'h0;
         S_AWREADY_O <= 1'b0;
         S_WREADY_O  <= 1'b0;
         S_BVALID_O  <= 1'b0;
         S_BRESP_O   <= tcr_pkg::RESP_OKAY;
      end else if (CLK_EN_I) begin
         // Refused while a response waits, so no second write slips in
         S_AWREADY_O <= !aw_held && !S_AWREADY_O && !S_BVALID_O;
         S_WREADY_O  <= !w_held && !S_WREADY_O && !S_BVALID_O;
         if (S_AWVALID_I && S_AWREADY_O) begin
            aw_held     <= 1'b1;
            aw_addr     <= S_AWADDR_I;
            S_AWREADY_O <= 1'b0;
         end
         if (S_WVALID_I && S_WREADY_O) begin
            w_held     <= 1'b1;
            w_data     <= S_WDATA_I;
            w_strb     <= S_WSTRB_I;
            S_WREADY_O <= 1'b0;
         end
         if (wr_go) begin
            aw_held    <= 1'b0;
            w_held     <= 1'b0;
            S_BVALID_O <= 1'b1;
            S_BRESP_O  <= idx_ok(wr_idx, aw_addr) ? tcr_pkg::RESP_OKAY
                                                  : tcr_pkg::RESP_SLVERR;
         end else if (S_BVALID_O && S_BREADY_I) begin
            S_BVALID_O <= 1'b0;
         end
      end
   end

   logic [7:0] rd_idx;
   logic [7:0] rd_byte;
   assign rd_idx = addr_idx(S_ARADDR_I);

   always_comb begin
      case (rd_idx)
         tcr_pkg::IDX_CONTROL:   rd_byte = ctl;
         tcr_pkg::IDX_MODE:      rd_byte = mode;
         tcr_pkg::IDX_CAPLOW:    rd_byte = cap[7:0];
         tcr_pkg::IDX_CAPHIGH:   rd_byte = cap[15:8];
         tcr_pkg::IDX_COUNTLOW:  rd_byte = cnt[7:0];
         tcr_pkg::IDX_COUNTHIGH: rd_byte = cnt[15:8];
         tcr_pkg::IDX_IRQSTATUS: rd_byte = {5'h00, irq_stat};
         tcr_pkg::IDX_IRQMASK:   rd_byte = {5'h00, irq_mask};
         tcr_pkg::IDX_AUX:       rd_byte = aux;
         default:                rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (SYS_RST_I) begin
         S_ARREADY_O <= 1'b0;
         S_RVALID_O  <= 1'b0;
         S_RDATA_O   <= 32'h0000_0000;
         S_RRESP_O   <= tcr_pkg::RESP_OKAY;
      end else if (CLK_EN_I) begin
         S_ARREADY_O <= !S_RVALID_O && !S_ARREADY_O;
         if (S_ARVALID_I && S_ARREADY_O) begin
            S_ARREADY_O <= 1'b0;
            S_RVALID_O  <= 1'b1;
            // An unmapped address reads zero whatever its index decodes to
            S_RDATA_O   <= idx_ok(rd_idx, S_ARADDR_I) ? {24'h00_0000, rd_byte}
                                                      : 32'h0000_0000;
            S_RRESP_O   <= idx_ok(rd_idx, S_ARADDR_I) ? tcr_pkg::RESP_OKAY
                                                      : tcr_pkg::RESP_SLVERR;
         end else if (S_RVALID_O && S_RREADY_I) begin
            S_RVALID_O <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Mode decode and tick generation
   logic baud_mode;
   logic trig_fall;
   logic pin_fall;
   logic pre_done;
   logic tick;
   logic down;
   logic [3:0] div;
   logic at_end;
   logic ovf;
   logic trig_act;
   logic do_capture;
   logic do_reload;

   assign baud_mode = ctl[tcr_pkg::CTL_RXB] | ctl[tcr_pkg::CTL_TXB];
   assign trig_fall = trig_q && !EXT_TRIGGER_PIN_I;
   assign pin_fall  = pin_q && !COUNT_INPUT_PIN_I;
   // Trigger acts only outside baud mode and when enabled
   assign trig_act  = trig_fall && ctl[tcr_pkg::CTL_EXEN] && !baud_mode;

   always_comb begin
      if (baud_mode) begin
         div = tcr_pkg::DIV_BAUD;
      end else if (aux[tcr_pkg::AUX_FAST]) begin
         div = tcr_pkg::DIV_FAST;
      end else begin
         div = tcr_pkg::DIV_SLOW;
      end
   end

   assign pre_done = (pre >= div - 4'h1);
   assign tick = ctl[tcr_pkg::CTL_RUN] &&
                 ((baud_mode || !ctl[tcr_pkg::CTL_CNT]) ? pre_done
                                                        : pin_fall);

   // Direction from trigger level only in plain auto-reload
   assign down = mode[tcr_pkg::MOD_DOWN_COUNT_ENABLE] && !ctl[tcr_pkg::CTL_CAP]
                 && !baud_mode && !EXT_TRIGGER_PIN_I;
   assign at_end = down ? (cnt == cap) : (cnt == tcr_pkg::ALL_ONES);
   assign ovf = tick && at_end;

   assign do_capture = trig_act && ctl[tcr_pkg::CTL_CAP];
   assign do_reload  = (ovf && (baud_mode || !ctl[tcr_pkg::CTL_CAP]) && !down)
                       || (trig_act && !ctl[tcr_pkg::CTL_CAP]);

   always_ff @(posedge CLK_SYS_I) begin
      if (SYS_RST_I) begin
         pre    <= 4'h0;
         trig_q <= 1'b1;
         pin_q  <= 1'b1;
      end else if (CLK_EN_I) begin
         trig_q <= EXT_TRIGGER_PIN_I;
         pin_q  <= COUNT_INPUT_PIN_I;
         if (!ctl[tcr_pkg::CTL_RUN] || pre_done) begin
            pre <= 4'h0;
         end else begin
            pre <= pre + 4'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Counter and capture/reload registers
   always_ff @(posedge CLK_SYS_I) begin
      if (SYS_RST_I) begin
         cnt <= tcr_pkg::RST_COUNT;
      end else if (CLK_EN_I) begin
         if (wr_cntl) begin
            cnt[7:0] <= w_data[7:0];
         end else if (wr_cnth) begin
            cnt[15:8] <= w_data[7:0];
         end else if (do_capture && mode[tcr_pkg::MOD_ACLR]) begin
            cnt <= tcr_pkg::RST_COUNT;
         end else if (do_reload) begin
            cnt <= cap;
         end else if (ovf && down) begin
            cnt <= tcr_pkg::ALL_ONES;
         end else if (tick) begin
            cnt <= down ? cnt - 16'h0001 : cnt + 16'h0001;
         end
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (SYS_RST_I) begin
         cap <= tcr_pkg::RST_COUNT;
      end else if (CLK_EN_I) begin
         if (do_capture) begin
            cap <= cnt;
         end else if (wr_capl) begin
            cap[7:0] <= w_data[7:0];
         end else if (wr_caph) begin
            cap[15:8] <= w_data[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Control, mode and aux registers; flags
   logic set_ovf;
   logic set_exf;
   assign set_ovf = ovf && !baud_mode;
   // Overflow sets the event flag only when down counting is enabled
   assign set_exf = trig_act ||
                    (ovf && mode[tcr_pkg::MOD_DOWN_COUNT_ENABLE] && !baud_mode);

   always_ff @(posedge CLK_SYS_I) begin
      if (SYS_RST_I) begin
         ctl  <= tcr_pkg::RST_BYTE;
         mode <= tcr_pkg::RST_BYTE;
         aux  <= tcr_pkg::RST_BYTE;
      end else if (CLK_EN_I) begin
         if (wr_ctl) begin
            ctl <= w_data[7:0];
         end
         if (wr_mode) begin
            mode <= w_data[7:0] & 8'h0B;
         end
         if (wr_aux) begin
            aux <= w_data[7:0] & 8'h01;
         end
         // Hardware sets win over a same-cycle software clear
         if (set_ovf) begin
            ctl[tcr_pkg::CTL_OVF] <= 1'b1;
         end
         if (set_exf) begin
            ctl[tcr_pkg::CTL_EXF] <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Interrupt status, mask and output
   logic [2:0] irq_ev;
   logic       exf_sw;
   assign exf_sw = wr_ctl
                   && w_data[tcr_pkg::CTL_EXF] && !ctl[tcr_pkg::CTL_EXF];
   assign irq_ev = {do_capture, set_exf || exf_sw, set_ovf};

   always_ff @(posedge CLK_SYS_I) begin
      if (SYS_RST_I) begin
         irq_stat <= 3'h0;
         irq_mask <= 3'h0;
         IRQ_O    <= 1'b0;
      end else if (CLK_EN_I) begin
         if (wr_irqs) begin
            irq_stat <= (irq_stat & ~w_data[2:0]) | irq_ev;
         end else begin
            irq_stat <= irq_stat | irq_ev;
         end
         if (wr_irqm) begin
            irq_mask <= w_data[2:0];
         end
         IRQ_O <= |(irq_stat & irq_mask);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Baud ticks and clock output
   always_ff @(posedge CLK_SYS_I) begin
      if (SYS_RST_I) begin
         RX_BAUD_TICK_O <= 1'b0;
         TX_BAUD_TICK_O <= 1'b0;
         CLOCK_OUT_O    <= 1'b0;
      end else if (CLK_EN_I) begin
         RX_BAUD_TICK_O <= ctl[tcr_pkg::CTL_RXB] ? ovf : TIMER1_OVF_I;
         TX_BAUD_TICK_O <= ctl[tcr_pkg::CTL_TXB] ? ovf : TIMER1_OVF_I;
         if (!mode[tcr_pkg::MOD_COE]) begin
            CLOCK_OUT_O <= 1'b0;
         end else if (ovf) begin
            CLOCK_OUT_O <= !CLOCK_OUT_O;
         end
      end
   end

endmodule

/* File: bench/tcr_pins_model.sv */
`timescale 1ns/1ps
module tcr_pins_model (
   // Clock
   input  wire logic CLK_SYS_I,
   // Pins toward the timer
   output      logic trig_o,
   output      logic count_o
);
   // Port pins rest high behind their pull-ups
   initial begin
      trig_o = 1'b1;
      count_o = 1'b1;
   end
   // Each level lasts several clocks so the sampled edge is never lost
   task automatic count_edges(input int n);
      repeat (n) begin
         @(posedge CLK_SYS_I);
         count_o <= 1'b0;
         repeat (3) @(posedge CLK_SYS_I);
         count_o <= 1'b1;
         repeat (3) @(posedge CLK_SYS_I);
      end
   endtask
   task automatic trig_fall();
      @(posedge CLK_SYS_I);
      trig_o <= 1'b0;
      repeat (4) @(posedge CLK_SYS_I);
      trig_o <= 1'b1;
      repeat (4) @(posedge CLK_SYS_I);
   endtask
   // Trigger level held for direction control
   task automatic trig_hold(input logic lvl);
      @(posedge CLK_SYS_I);
      trig_o <= lvl;
   endtask
endmodule

/* File: bench/tcr_timer_monitor.sv */
`timescale 1ns/1ps
module tcr_timer_monitor #(
   parameter int ADDR_W = 12
) (
   // Clock and reset
   input wire logic              CLK_SYS_I,
   input wire logic              SYS_RST_I,
   // Write side
   input wire logic              S_AWVALID_I,
   input wire logic              S_AWREADY_O,
   input wire logic              S_WREADY_O,
   input wire logic              S_BVALID_O,
   // Read side
   input wire logic [ADDR_W-1:0] S_ARADDR_I,
   input wire logic              S_ARVALID_I,
   input wire logic              S_ARREADY_O,
   input wire logic [31:0]       S_RDATA_O,
   input wire logic [1:0]        S_RRESP_O,
   input wire logic              S_RVALID_O
);
   default clocking cb @(posedge CLK_SYS_I);
   endclocking
   default disable iff (SYS_RST_I);
   logic ar_hit;
   // A hit is an index inside the byte register map; low bits ignored
   assign ar_hit = S_ARADDR_I[ADDR_W-1:2] >= tcr_pkg::IDX_CONTROL
      && S_ARADDR_I[ADDR_W-1:2] <= tcr_pkg::IDX_AUX;
   sequence s_aw_taken;
      S_AWVALID_I && S_AWREADY_O;
   endsequence
   sequence s_ar_taken;
      S_ARVALID_I && S_ARREADY_O;
   endsequence
   chk_bresp_due: assert property (s_aw_taken |-> ##[1:6] S_BVALID_O)
      else $error("write response missing");
   chk_rvalid_next: assert property (s_ar_taken |=> S_RVALID_O)
      else $error("read response late");
   chk_rvalid_cause: assert property
      ($rose(S_RVALID_O) |-> $past(S_ARVALID_I && S_ARREADY_O))
      else $error("read response without request");
   chk_wr_busy: assert property
      (S_BVALID_O |-> !S_AWREADY_O && !S_WREADY_O)
      else $error("write taken while response pending");
   chk_rd_busy: assert property (S_RVALID_O |-> !S_ARREADY_O)
      else $error("read taken while response pending");
   chk_upper_zero: assert property
      (S_RVALID_O |-> S_RDATA_O[31:8] == 24'h00_0000)
      else $error("upper read data not zero");
   chk_map_error: assert property (S_ARVALID_I && S_ARREADY_O && !ar_hit
      |=> S_RRESP_O == tcr_pkg::RESP_SLVERR && S_RDATA_O == 32'h0000_0000)
      else $error("unmapped read not refused");
   chk_map_okay: assert property (S_ARVALID_I && S_ARREADY_O && ar_hit
      |=> S_RRESP_O == tcr_pkg::RESP_OKAY)
      else $error("mapped read refused");
endmodule
bind tcr_timer tcr_timer_monitor #(.ADDR_W(ADDR_W)) chk_u (
   .CLK_SYS_I, .SYS_RST_I, .S_AWVALID_I, .S_AWREADY_O, .S_WREADY_O,
   .S_BVALID_O, .S_ARADDR_I, .S_ARVALID_I, .S_ARREADY_O, .S_RDATA_O,
   .S_RRESP_O, .S_RVALID_O
);

/* File: bench/tcr_timer_tb.sv */
`timescale 1ns/1ps
module tcr_timer_tb;
   localparam logic [7:0] CTL = tcr_pkg::IDX_CONTROL;
   localparam logic [7:0] CNTL = tcr_pkg::IDX_COUNTLOW;
   localparam logic [7:0] RUN = 8'h01 << tcr_pkg::CTL_RUN;
   localparam logic [7:0] CNT = 8'h01 << tcr_pkg::CTL_CNT;
   localparam logic [7:0] CAP = 8'h01 << tcr_pkg::CTL_CAP;
   localparam logic [7:0] EXEN = 8'h01 << tcr_pkg::CTL_EXEN;
   localparam logic [7:0] EXF = 8'h01 << tcr_pkg::CTL_EXF;
   localparam logic [7:0] OVF = 8'h01 << tcr_pkg::CTL_OVF;
   localparam logic [7:0] RXB = 8'h01 << tcr_pkg::CTL_RXB;
   localparam logic [7:0] EXM = 8'h01 << tcr_pkg::IRQ_EXF;
   localparam logic [7:0] OVM = 8'h01 << tcr_pkg::IRQ_OVF;
   logic        clk = 1'b0, rst = 1'b1, en = 1'b1, t1 = 1'b0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0, c;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0000_0000, rdata, rdat;
   logic [1:0]  bresp, rresp, brsp, rrsp;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        clkout, rxt, txt, irq, trig, cnt;
   logic [7:0]  v, h;
   int          n_errors = 0, checks = 0, cyc = 0, t;
   tcr_pins_model pins_u (.CLK_SYS_I(clk), .trig_o(trig), .count_o(cnt));
   tcr_timer dut_u (.CLK_SYS_I(clk), .SYS_RST_I(rst), .CLK_EN_I(en),
      .S_AWADDR_I(awaddr), .S_AWVALID_I(awvalid), .S_AWREADY_O(awready),
      .S_WDATA_I(wdata), .S_WSTRB_I(4'h1), .S_WVALID_I(wvalid),
      .S_WREADY_O(wready), .S_BRESP_O(bresp), .S_BVALID_O(bvalid),
      .S_BREADY_I(bready), .S_ARADDR_I(araddr), .S_ARVALID_I(arvalid),
      .S_ARREADY_O(arready), .S_RDATA_O(rdata), .S_RRESP_O(rresp),
      .S_RVALID_O(rvalid), .S_RREADY_I(rready),
      .EXT_TRIGGER_PIN_I(trig), .COUNT_INPUT_PIN_I(cnt),
      .TIMER1_OVF_I(t1), .CLOCK_OUT_O(clkout), .RX_BAUD_TICK_O(rxt),
      .TX_BAUD_TICK_O(txt), .IRQ_O(irq));
   always #4 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // A hang anywhere ends here rather than stalling the run
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         finish_test();
      end
   end
   task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Bit results are compared at once; each caller samples them on a falling edge
   task automatic cmp_bit(input logic got, input logic exp);
      cmp_reg({31'h0000_0000, got}, {31'h0000_0000, exp});
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      logic a, w;
      a = 1'b0;
      w = 1'b0;
      @(posedge clk);
      awaddr <= {2'h0, i, 2'h0};
      wdata <= {24'h00_0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(a && w)) begin
         @(negedge clk);
         a = a | awready;
         w = w | wready;
         @(posedge clk);
         if (a) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
      end
      do @(negedge clk); while (bvalid !== 1'b1);
      brsp = bresp;
      @(posedge clk);
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] i);
      @(posedge clk);
      araddr <= {2'h0, i, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(negedge clk); while (arready !== 1'b1);
      @(posedge clk);
      arvalid <= 1'b0;
      do @(negedge clk); while (rvalid !== 1'b1);
      rdat = rdata;
      rrsp = rresp;
      @(posedge clk);
      rready <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] i, input logic [7:0] e);
      rd(i);
      cmp_reg(rdat, {24'h00_0000, e});
   endtask
   task automatic irq_chk(input logic e);
      repeat (3) @(negedge clk);
      cmp_bit(irq, e);
   endtask
   task automatic t1_pulse();
      @(posedge clk);
      t1 <= 1'b1;
      @(posedge clk);
      t1 <= 1'b0;
      @(negedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      v = 8'($urandom(57089));
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rdc(CTL, 8'h00);
      for (int k = 0; k < 4; k++) begin
         v = 8'($urandom);
         wr(8'hCA + 8'(k), v);
         rdc(8'hCA + 8'(k), v);
      end
      rd(8'hF0);
      cmp_reg(32'(rrsp) | rdat, 32'(tcr_pkg::RESP_SLVERR));
      wr(8'hF0, 8'hFF);
      cmp_reg(32'(brsp), 32'(tcr_pkg::RESP_SLVERR));
      // Counting halts without the run bit, and carries reach the high byte
      wr(CNTL, 8'hFE);
      wr(CNTL + 8'h01, 8'h00);
      wr(CTL, CNT);
      pins_u.count_edges(2);
      rdc(CNTL, 8'hFE);
      wr(CTL, CNT | RUN);
      pins_u.count_edges(3);
      rdc(CNTL, 8'h01);
      rdc(CNTL + 8'h01, 8'h01);
      // Edges that come while the clock enable is low are never seen
      @(posedge clk);
      en <= 1'b0;
      pins_u.count_edges(1);
      en <= 1'b1;
      rdc(CNTL, 8'h01);
      // Capture with auto-clear, event flag and its interrupt
      v = 8'($urandom);
      wr(8'hCF, EXM);
      wr(8'hC9, 8'h01 << tcr_pkg::MOD_ACLR);
      wr(CNTL, v);
      wr(CNTL + 8'h01, 8'h12);
      wr(CTL, EXEN | RUN | CNT | CAP);
      pins_u.trig_fall();
      rdc(8'hCA, v);
      rdc(8'hCB, 8'h12);
      rdc(CNTL + 8'h01, 8'h00);
      rdc(CTL, EXF | EXEN | RUN | CNT | CAP);
      irq_chk(1'b1);
      wr(8'hCE, EXM);
      irq_chk(1'b0);
      wr(8'hCF, 8'h00);
      wr(CTL, 8'h00);
      wr(CTL, EXF);
      irq_chk(1'b0);
      wr(8'hCF, EXM);
      irq_chk(1'b1);
      wr(8'hCE, EXM);
      wr(CTL, RUN | CNT | CAP);
      pins_u.trig_fall();
      rdc(8'hCB, 8'h12);
      // Overflow in fast timer mode reloads and keeps its flag
      h = 8'($urandom);
      wr(8'hC9, 8'h00);
      wr(8'hD0, 8'h01 << tcr_pkg::AUX_FAST);
      wr(8'hCF, OVM);
      wr(8'hCA, 8'h10);
      wr(8'hCB, h);
      wr(CNTL, 8'hFF);
      wr(CNTL + 8'h01, 8'hFF);
      wr(CTL, RUN);
      for (t = 0; t < 60 && irq !== 1'b1; t++) @(negedge clk);
      cmp_bit(irq, 1'b1);
      rdc(CTL, OVF | RUN);
      rdc(CNTL + 8'h01, h);
      wr(8'hCE, OVM);
      irq_chk(1'b0);
      rdc(CTL, OVF | RUN);
      wr(CTL, 8'h00);
      rdc(CTL, 8'h00);
      // Baud generator: reload every overflow, ticks and clock output
      wr(8'hCA, 8'hFE);
      wr(8'hCB, 8'hFF);
      wr(CNTL, 8'hFE);
      wr(CNTL + 8'h01, 8'hFF);
      wr(8'hC9, 8'h01 << tcr_pkg::MOD_COE);
      wr(CTL, RXB | RUN | CNT | CAP);
      do @(negedge clk); while (rxt !== 1'b1);
      c = clkout;
      t = 0;
      do begin
         @(negedge clk);
         t++;
      end while (rxt !== 1'b1 && t < 40);
      cmp_reg(32'(t), 32'h0000_0004);
      cmp_bit(clkout, !c);
      rdc(CTL, RXB | RUN | CNT | CAP);
      t1_pulse();
      cmp_bit(txt, 1'b1);
      wr(8'hC9, 8'h00);
      irq_chk(1'b0);
      cmp_bit(clkout, 1'b0);
      wr(CTL, 8'h00);
      t1_pulse();
      cmp_bit(rxt, 1'b1);
      // Low trigger level counts down and wraps at the reload value
      wr(8'hC9, 8'h01 << tcr_pkg::MOD_DOWN_COUNT_ENABLE);
      wr(8'hCA, 8'h00);
      wr(8'hCB, 8'h00);
      wr(CNTL, 8'h02);
      wr(CNTL + 8'h01, 8'h00);
      pins_u.trig_hold(1'b0);
      wr(CTL, RUN);
      for (t = 0; t < 60 && irq !== 1'b1; t++) @(negedge clk);
      cmp_bit(irq, 1'b1);
      rdc(CTL, OVF | EXF | RUN);
      rdc(CNTL + 8'h01, 8'hFF);
      finish_test();
   end
endmodule
